// ### fsb_addr_pkg.sv
// Package: widths, field positions, reset values and timing for the address phase block.
// Assumes one core clock mclk at 100 MHz; the link strobes are sampled, not used as clocks.
package fsb_addr_pkg;
    localparam int ADDR_W = 29;              // Address lines carry bits 31..3
    localparam int ADDR_LSB = 3;
    localparam int REQ_W = 5;
    localparam int STB_W = 2;
    localparam int LO_W = 14;                // Bits 16..3 ride on strobe 0
    localparam int HI_W = 15;                // Bits 31..17 ride on strobe 1
    localparam int A20_POS = 20 - ADDR_LSB;  // Bit 20 inside the 29-bit field
    localparam logic [28:0] ADDR_RST = 29'h0000_0000;
    localparam logic [4:0] REQ_RST = 5'h0_0;
    localparam logic [1:0] STB_IDLE_N = 2'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STB_TIMEOUT_NS = 2000;    // Longest wait for the strobes of a sub-phase, counted from valid or from the end of sub-phase 1
    localparam int STB_TIMEOUT_CYC = STB_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] STB_TIMEOUT_CNT = 8'(STB_TIMEOUT_CYC);
endpackage : fsb_addr_pkg

// ### sync2.sv
// Two-flop synchroniser for pin inputs, one per bit.
// Assumes the input is asynchronous to mclk; only the second flop is read.
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    // Next values
    always_comb begin
        meta_d = din;
        out_d = meta_q;
    end

    // First flop runs through reset, so it already holds the pin level when reset lifts
    always_ff @(posedge mclk) begin
        meta_q <= meta_d;
    end

    // Second flop reset to the idle pin level, so no false edge follows reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            out_q <= RST;
        end else begin
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule // sync2

// ### fsb_address_phase.sv
// Address-phase unit of a front side bus agent: drives and receives the address phase.
// Assumes active-low pins resolved by the bench from enables, strobes slow against mclk.
// Operation
// - Sub-phase 1 drives the byte-block address bits 31..3 on the address lines.
// - Sub-phase 2 reuses the same lines to carry the transaction type.
// - Receiver captures address lines on address strobe edges, not the bus clock.
// - Address lines are sampled as straps before reset is released.
// - Mask input forces address bit 20 low before lookup and bus access.
// - Requester asserts address-valid strobe when address and request lines are valid.
// - All agents start decode and checks when address-valid strobe activates; this block only on strobes it does not drive itself.
// - Strobe 0 qualifies request lines and bits 16..3; strobe 1 bits 31..17.
`timescale 1ns/10ps
module fsb_address_phase (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Internal request side
    input wire logic req_start,
    input wire logic [28:0] req_addr,
    input wire logic [4:0] req_type_a,
    input wire logic [28:0] req_type_b,
    output logic req_busy,
    // Mask pin and platform handshake
    input wire logic addr_bit20_mask_n,
    input wire logic target_ready_n,
    // Address lines, three signals each
    input wire logic [28:0] addr_n_i,
    output logic [28:0] addr_n_o,
    output logic [28:0] addr_n_oe,
    input wire logic [4:0] req_n_i,
    output logic [4:0] req_n_o,
    output logic [4:0] req_n_oe,
    input wire logic [1:0] addr_source_strobes_n_i,
    output logic [1:0] addr_source_strobes_n_o,
    output logic [1:0] addr_source_strobes_n_oe,
    input wire logic addr_valid_strobe_n_i,
    output logic addr_valid_strobe_n_o,
    output logic addr_valid_strobe_n_oe,
    // Received transaction, straps and mask state
    output logic rx_valid,
    output logic [28:0] rx_addr,
    output logic [4:0] rx_req_a,
    output logic [28:0] rx_type_b,
    output logic rx_start,
    output logic rx_timeout,
    output logic [28:0] strap_q_o,
    output logic mask_active
);
    typedef enum logic [2:0] {TX_IDLE, TX_P1, TX_P1H, TX_P2, TX_P2H} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_P1, RX_P2} rx_state_t;

    // Active-low pin to logic-one conversion, used on the address lines only
    function automatic logic [28:0] pin_to_val(input logic [28:0] p);
        return ~p;
    endfunction

    logic [28:0] addr_s;
    logic [4:0] req_s;
    logic [1:0] stb_s;
    logic ads_s;
    logic mask_s;
    logic target_ready_s;
    logic [28:0] addr_v;

    // Every pin passes two flops before any logic reads it
    sync2 #(.W(29), .RST('1)) u_sa (.mclk(mclk), .rstn(rstn), .din(addr_n_i), .dout(addr_s));
    sync2 #(.W(5), .RST('1)) u_sr (.mclk(mclk), .rstn(rstn), .din(req_n_i), .dout(req_s));
    sync2 #(.W(2), .RST('1)) u_ss (.mclk(mclk), .rstn(rstn), .din(addr_source_strobes_n_i), .dout(stb_s));
    sync2 #(.W(1), .RST('1)) u_sv (.mclk(mclk), .rstn(rstn), .din(addr_valid_strobe_n_i), .dout(ads_s));
    sync2 #(.W(1), .RST('1)) u_sm (.mclk(mclk), .rstn(rstn), .din(addr_bit20_mask_n), .dout(mask_s));
    sync2 #(.W(1), .RST('1)) u_st (.mclk(mclk), .rstn(rstn), .din(target_ready_n), .dout(target_ready_s));

    // Address lines in logic-one polarity; a function result cannot be part-selected
    assign addr_v = pin_to_val(addr_s);

    // ---------------- Transmit side ----------------
    tx_state_t tx_q, tx_d;
    logic [28:0] tx_addr_q, tx_addr_d;
    logic [4:0] tx_req_q, tx_req_d;
    logic [28:0] tx_b_q, tx_b_d;
    logic [1:0] stb_o_q, stb_o_d;
    logic ads_o_q, ads_o_d;
    logic drive_q, drive_d;
    logic mask_q, mask_d;
    logic busy_q, busy_d;
    logic [28:0] masked_addr;

    // Mask is loaded on reset release and refreshed in every idle cycle or once the platform shows target ready,
    // so a write that toggles the mask acts on the next transaction
    always_comb begin
        mask_d = mask_q;
        if (!target_ready_s || tx_q == TX_IDLE) begin
            mask_d = ~mask_s;
        end
    end

    // Bit 20 cleared before the address leaves the block
    always_comb begin
        masked_addr = req_addr;
        if (mask_q) begin
            masked_addr[fsb_addr_pkg::A20_POS] = 1'b0;
        end
    end

    // Two sub-phases, each strobed with a falling then rising edge
    always_comb begin
        tx_d = tx_q;
        tx_addr_d = tx_addr_q;
        tx_req_d = tx_req_q;
        tx_b_d = tx_b_q;
        stb_o_d = fsb_addr_pkg::STB_IDLE_N;
        ads_o_d = 1'b1;
        drive_d = drive_q;
        busy_d = busy_q;
        unique case (tx_q)
            TX_IDLE: begin
                drive_d = 1'b0;
                busy_d = 1'b0;
                if (req_start && ads_s) begin
                    tx_d = TX_P1;
                    tx_addr_d = ~masked_addr;
                    tx_req_d = ~req_type_a;
                    tx_b_d = ~req_type_b;
                    drive_d = 1'b1;
                    busy_d = 1'b1;
                    ads_o_d = 1'b0;
                end
            end
            TX_P1: begin
                stb_o_d = 2'h0;
                tx_d = TX_P1H;
            end
            TX_P1H: begin
                tx_addr_d = tx_b_q;
                tx_req_d = ~fsb_addr_pkg::REQ_RST; // Request pins high, value zero
                tx_d = TX_P2;
            end
            TX_P2: begin
                stb_o_d = 2'h0;
                tx_d = TX_P2H;
            end
            TX_P2H: begin
                tx_d = TX_IDLE;
            end
            default: tx_d = TX_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tx_q <= TX_IDLE;
            tx_addr_q <= '1;
            tx_req_q <= '1;
            tx_b_q <= '1;
            stb_o_q <= fsb_addr_pkg::STB_IDLE_N;
            ads_o_q <= 1'b1;
            drive_q <= 1'b0;
            mask_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            tx_q <= tx_d;
            tx_addr_q <= tx_addr_d;
            tx_req_q <= tx_req_d;
            tx_b_q <= tx_b_d;
            stb_o_q <= stb_o_d;
            ads_o_q <= ads_o_d;
            drive_q <= drive_d;
            mask_q <= mask_d;
            busy_q <= busy_d;
        end
    end

    assign addr_n_o = tx_addr_q;
    assign addr_n_oe = {29{drive_q}};
    assign req_n_o = tx_req_q;
    assign req_n_oe = {5{drive_q}};
    assign addr_source_strobes_n_o = stb_o_q;
    assign addr_source_strobes_n_oe = {2{drive_q}};
    assign addr_valid_strobe_n_o = ads_o_q;
    assign addr_valid_strobe_n_oe = drive_q;
    assign req_busy = busy_q;
    assign mask_active = mask_q;

    // ---------------- Receive side ----------------
    rx_state_t rx_q, rx_d;
    logic [1:0] stb_prev_q, stb_prev_d;
    logic ads_prev_q, ads_prev_d;
    logic [28:0] rxa_q, rxa_d;
    logic [4:0] rxr_q, rxr_d;
    logic [28:0] rxb_q, rxb_d;
    logic [1:0] got_q, got_d;
    logic val_q, val_d;
    logic start_q, start_d;
    logic tmo_q, tmo_d;
    logic [7:0] wait_q, wait_d;
    logic [28:0] strap_q, strap_d;
    logic strap_done_q, strap_done_d;
    logic strap_arm_q, strap_arm_d;
    logic [1:0] fall;
    logic ads_fall;

    assign fall = stb_prev_q & ~stb_s;
    assign ads_fall = ads_prev_q & ~ads_s & ~drive_q;

    // Capture on strobe falls; each half of the lines by its own strobe
    always_comb begin
        rx_d = rx_q;
        stb_prev_d = stb_s;
        ads_prev_d = ads_s;
        rxa_d = rxa_q;
        rxr_d = rxr_q;
        rxb_d = rxb_q;
        got_d = got_q;
        val_d = 1'b0;
        start_d = 1'b0;
        tmo_d = 1'b0;
        wait_d = wait_q;
        strap_d = strap_q;
        strap_done_d = strap_done_q;
        strap_arm_d = 1'b1;
        // Second edge after release: the sync output then holds the pins seen during reset
        if (strap_arm_q && !strap_done_q) begin
            strap_d = addr_v;
            strap_done_d = 1'b1;
        end
        unique case (rx_q)
            RX_IDLE: begin
                if (ads_fall) begin
                    start_d = 1'b1;
                    rx_d = RX_P1;
                    got_d = 2'h0;
                    wait_d = '0;
                end
            end
            RX_P1, RX_P2: begin
                wait_d = wait_q + 8'h01;
                if (fall[0]) begin
                    if (rx_q == RX_P1) begin
                        rxa_d[fsb_addr_pkg::LO_W-1:0] = addr_v[fsb_addr_pkg::LO_W-1:0];
                        rxr_d = ~req_s;
                    end else begin
                        rxb_d[fsb_addr_pkg::LO_W-1:0] = addr_v[fsb_addr_pkg::LO_W-1:0];
                    end
                end
                if (fall[1]) begin
                    if (rx_q == RX_P1) begin
                        rxa_d[28:fsb_addr_pkg::LO_W] = addr_v[28:fsb_addr_pkg::LO_W];
                    end else begin
                        rxb_d[28:fsb_addr_pkg::LO_W] = addr_v[28:fsb_addr_pkg::LO_W];
                    end
                end
                got_d = got_q | fall;
                if (got_d == 2'h3) begin
                    got_d = 2'h0;
                    wait_d = '0;
                    if (rx_q == RX_P1) begin
                        rx_d = RX_P2;
                    end else begin
                        rx_d = RX_IDLE;
                        val_d = 1'b1;
                    end
                end else if (wait_q == fsb_addr_pkg::STB_TIMEOUT_CNT) begin
                    rx_d = RX_IDLE;
                    tmo_d = 1'b1;
                end
            end
            default: rx_d = RX_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rx_q <= RX_IDLE;
            stb_prev_q <= fsb_addr_pkg::STB_IDLE_N;
            ads_prev_q <= 1'b1;
            rxa_q <= fsb_addr_pkg::ADDR_RST;
            rxr_q <= fsb_addr_pkg::REQ_RST;
            rxb_q <= fsb_addr_pkg::ADDR_RST;
            got_q <= 2'h0;
            val_q <= 1'b0;
            start_q <= 1'b0;
            tmo_q <= 1'b0;
            wait_q <= '0;
            strap_q <= fsb_addr_pkg::ADDR_RST;
            strap_done_q <= 1'b0;
            strap_arm_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            stb_prev_q <= stb_prev_d;
            ads_prev_q <= ads_prev_d;
            rxa_q <= rxa_d;
            rxr_q <= rxr_d;
            rxb_q <= rxb_d;
            got_q <= got_d;
            val_q <= val_d;
            start_q <= start_d;
            tmo_q <= tmo_d;
            wait_q <= wait_d;
            strap_q <= strap_d;
            strap_done_q <= strap_done_d;
            strap_arm_q <= strap_arm_d;
        end
    end

    assign rx_valid = val_q;
    assign rx_addr = rxa_q;
    assign rx_req_a = rxr_q;
    assign rx_type_b = rxb_q;
    assign rx_start = start_q;
    assign rx_timeout = tmo_q;
    assign strap_q_o = strap_q;

    // Checks
    bit20_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        (tx_q == TX_IDLE && tx_d == TX_P1 && mask_q) |=> tx_addr_q[fsb_addr_pkg::A20_POS])
        else $error("bit 20 not forced low");
    valid_drive_a: assert property (@(posedge mclk) disable iff (!rstn)
        !ads_o_q |-> drive_q ##1 !stb_o_q[0] && !stb_o_q[1])
        else $error("valid strobe without strobes");
    phase_two_a: assert property (@(posedge mclk) disable iff (!rstn)
        (tx_q == TX_P1H) |=> (tx_addr_q == tx_b_q) ##1 (stb_o_q == 2'h0))
        else $error("sub-phase 2 not driven");
    rx_start_a: assert property (@(posedge mclk) disable iff (!rstn)
        (ads_fall && rx_q == RX_IDLE) |=> rx_start && rx_q == RX_P1)
        else $error("decode not started");
    rx_done_a: assert property (@(posedge mclk) disable iff (!rstn)
        rx_start |-> ##[1:210] (rx_valid || rx_timeout))
        else $error("receive never ended");
    strap_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        strap_done_q |=> $stable(strap_q))
        else $error("strap moved after reset");
    oe_idle_a: assert property (@(posedge mclk) disable iff (!rstn)
        (tx_q == TX_IDLE && !drive_q) |-> addr_valid_strobe_n_o && stb_o_q == 2'h3)
        else $error("idle pins not high");
    mask_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        (tx_q == TX_IDLE) |=> mask_q == !$past(mask_s))
        else $error("mask not refreshed");
endmodule // fsb_address_phase

// ### fsb_hub_model.sv
// Hub-side model of the address phase: sends transactions and captures those of the block.
// Assumes resolved active-low pins pulled high when idle; link strobes at a 160 ns period.
`timescale 1ns/10ps
module fsb_hub_model (
    // Resolved pins
    input wire logic [28:0] addr_n,
    input wire logic [4:0] req_n,
    input wire logic [1:0] stb_n,
    input wire logic valid_n,
    // Hub drive, all ones when released
    output logic [28:0] addr_n_drv,
    output logic [4:0] req_n_drv,
    output logic [1:0] stb_n_drv,
    output logic valid_n_drv,
    // Captured transaction, logic-one polarity
    output logic [28:0] cap_addr,
    output logic [4:0] cap_req,
    output logic [28:0] cap_type,
    output int cap_cnt
);
    localparam int HALF = 80;
    int sub0 = 0;
    int sub1 = 0;
    bit drv = 0;
    // Released lines float to the termination level
    task automatic release_all();
        addr_n_drv = '1;
        req_n_drv = '1;
        stb_n_drv = '1;
        valid_n_drv = 1'b1;
        drv = 0;
    endtask
    // Straps must stand on the address lines across reset release
    task automatic strap(input logic [28:0] v);
        addr_n_drv = ~v;
    endtask
    // Full two sub-phase transaction; each strobe falls mid-way through stable data
    task automatic send(input logic [28:0] a, input logic [4:0] r, input logic [28:0] t);
        drv = 1;
        addr_n_drv = ~a;
        req_n_drv = ~r;
        valid_n_drv = 1'b0;
        #HALF stb_n_drv = 2'h0;
        #HALF stb_n_drv = 2'h3;
        valid_n_drv = 1'b1;
        addr_n_drv = ~t;
        req_n_drv = 5'h1f;
        #HALF stb_n_drv = 2'h0;
        #HALF stb_n_drv = 2'h3;
        #HALF release_all();
    endtask
    // Valid strobe with no strobes following, to make the receiver give up
    task automatic abort();
        drv = 1;
        valid_n_drv = 1'b0;
        #HALF release_all();
    endtask
    initial begin
        release_all();
        cap_cnt = 0;
    end
    // New transaction restarts both sub-phase counts
    always @(negedge valid_n) if (!drv) begin
        sub0 = 0;
        sub1 = 0;
    end
    // Strobe 0 qualifies request lines and bits 16..3
    always @(negedge stb_n[0]) if (!drv) begin
        if (sub0 == 0) begin
            cap_addr[13:0] = ~addr_n[13:0];
            cap_req = ~req_n;
        end else begin
            cap_type[13:0] = ~addr_n[13:0];
        end
        sub0++;
    end
    // Strobe 1 qualifies bits 31..17 and closes the transaction
    always @(negedge stb_n[1]) if (!drv) begin
        if (sub1 == 0) begin
            cap_addr[28:14] = ~addr_n[28:14];
        end else begin
            cap_type[28:14] = ~addr_n[28:14];
            cap_cnt++;
        end
        sub1++;
    end
endmodule // fsb_hub_model

// ### fsb_address_phase_test.sv
// Self-checking bench for the address phase block against a queue model and the hub model.
// Assumes the hub model above; pins resolve as a wired AND with termination high.
`timescale 1ns/10ps
module fsb_address_phase_test;
    logic mclk = 0;
    logic rstn = 0;
    logic req_start = 0;
    logic [28:0] req_addr = 29'h0000_0000;
    logic [4:0] req_type_a = 5'h00;
    logic [28:0] req_type_b = 29'h0000_0000;
    logic addr_bit20_mask_n = 1;
    logic target_ready_n = 1;
    logic req_busy, rx_valid, rx_start, rx_timeout, mask_active, v_o, v_oe, h_v, v_w;
    logic [28:0] a_o, a_oe, rx_addr, rx_type_b, strap_q_o, cap_addr, cap_type, h_a, a_w, sv, ta, tb;
    logic [4:0] r_o, r_oe, rx_req_a, cap_req, h_r, r_w, tr;
    logic [1:0] s_o, s_oe, h_s, s_w;
    int cap_cnt, seen = 0, num_errors = 0, checks_done = 0, starts = 0, touts = 0;
    bit mref = 0;
    integer seed = 32'h955e_4aee;
    logic [62:0] tx_q[$];
    logic [62:0] rx_q[$];
    // Clock and wired-AND pin resolution
    always #5 mclk = ~mclk;
    assign a_w = (a_o | ~a_oe) & h_a;
    assign r_w = (r_o | ~r_oe) & h_r;
    assign s_w = (s_o | ~s_oe) & h_s;
    assign v_w = (v_o | ~v_oe) & h_v;
    fsb_address_phase i_fsb_address_phase (.mclk(mclk), .rstn(rstn), .req_start(req_start),
        .req_addr(req_addr), .req_type_a(req_type_a), .req_type_b(req_type_b), .req_busy(req_busy),
        .addr_bit20_mask_n(addr_bit20_mask_n), .target_ready_n(target_ready_n), .addr_n_i(a_w),
        .addr_n_o(a_o), .addr_n_oe(a_oe), .req_n_i(r_w), .req_n_o(r_o), .req_n_oe(r_oe),
        .addr_source_strobes_n_i(s_w), .addr_source_strobes_n_o(s_o), .addr_source_strobes_n_oe(s_oe),
        .addr_valid_strobe_n_i(v_w), .addr_valid_strobe_n_o(v_o), .addr_valid_strobe_n_oe(v_oe),
        .rx_valid(rx_valid), .rx_addr(rx_addr), .rx_req_a(rx_req_a), .rx_type_b(rx_type_b),
        .rx_start(rx_start), .rx_timeout(rx_timeout), .strap_q_o(strap_q_o), .mask_active(mask_active));
    fsb_hub_model i_fsb_hub_model (.addr_n(a_w), .req_n(r_w), .stb_n(s_w), .valid_n(v_w),
        .addr_n_drv(h_a), .req_n_drv(h_r), .stb_n_drv(h_s), .valid_n_drv(h_v),
        .cap_addr(cap_addr), .cap_req(cap_req), .cap_type(cap_type), .cap_cnt(cap_cnt));
    task automatic cmp(input logic [62:0] got, input logic [62:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Random request; poke tries a second start while busy, which must be ignored
    task automatic tx(input bit poke);
        @(negedge mclk);
        req_addr = 29'($random(seed)) | (29'(mref) << fsb_addr_pkg::A20_POS);
        req_type_a = 5'($random(seed));
        req_type_b = 29'($random(seed));
        req_start = 1;
        ta = mref ? req_addr & ~(29'h1 << fsb_addr_pkg::A20_POS) : req_addr;
        tx_q.push_back({ta, req_type_a, req_type_b});
        @(negedge mclk);
        req_start = 0;
        @(negedge mclk);
        req_start = poke;
        @(negedge mclk);
        req_start = 0;
        for (int i = 0; i < 20 && req_busy !== 1'b0; i++) @(negedge mclk);
        repeat (2) @(negedge mclk);
    endtask
    // Monitor: every result checked against the queue model
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) cmp({rx_addr, rx_req_a, rx_type_b}, rx_q.pop_front());
        if (cap_cnt != seen) begin
            seen++;
            cmp({cap_addr, cap_req, cap_type}, tx_q.pop_front());
        end
        if (rx_start === 1'b1) starts++;
        if (rx_timeout === 1'b1) touts++;
    end
    initial begin
        #200000;
        num_errors++;
        results();
    end
    initial begin
        sv = 29'($random(seed));
        i_fsb_hub_model.strap(sv);
        repeat (4) @(negedge mclk);
        rstn = 1;
        repeat (2) @(negedge mclk);
        i_fsb_hub_model.release_all();
        cmp({34'h0, strap_q_o}, {34'h0, sv});
        repeat (3) @(negedge mclk);
        for (int i = 0; i < 6; i++) tx(i == 2);
        // Mask on: bit 20 must leave on the pins as zero, pin level high
        addr_bit20_mask_n = 0;
        repeat (5) @(negedge mclk);
        mref = 1;
        cmp({62'h0, mask_active}, 63'h1);
        for (int i = 0; i < 3; i++) tx(0);
        // Mask dropped mid-transfer, made valid with target ready
        fork
            tx(0);
            begin
                repeat (3) @(negedge mclk);
                addr_bit20_mask_n = 1;
                target_ready_n = 0;
                @(negedge mclk);
                target_ready_n = 1;
            end
        join
        mref = 0;
        cmp({62'h0, mask_active}, 63'h0);
        tx(0);
        // Receive side driven by the hub
        for (int i = 0; i < 4; i++) begin
            ta = 29'($random(seed));
            tr = 5'($random(seed));
            tb = 29'($random(seed));
            rx_q.push_back({ta, tr, tb});
            i_fsb_hub_model.send(ta, tr, tb);
            repeat (10) @(negedge mclk);
        end
        cmp(63'(starts), 63'h4);
        i_fsb_hub_model.abort();
        for (int i = 0; i < 300 && touts == 0; i++) @(negedge mclk);
        cmp(63'(touts), 63'h1);
        cmp(63'(tx_q.size() + rx_q.size()), 63'h0);
        results();
    end
endmodule // fsb_address_phase_test
